// ===== core/pport_pkg.sv
// Package for the eight-bit parallel host port: modes, states and carriers.
// Assumes one core clock domain; the USB side is a plain user port list.
package pport_pkg;

    localparam int DATA_W = 8;
    localparam logic RST_FLAG_OE_N = 1'b1;
    localparam logic [1:0] RD_IDLE = 2'h0;

    // Port personality selected by configuration memory and host command
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_FIFO = 2'b01,
        MODE_BITBANG = 2'b10
    } port_mode_t;

    // Read strobe sequence in FIFO mode
    typedef enum logic [1:0] {
        RD_WAIT = 2'b00,
        RD_DRIVE = 2'b01,
        RD_DONE = 2'b10
    } rd_state_t;

    // One byte with its valid, used on both USB-facing streams
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } byte_beat_t;

    // Output half of a two-way pin group: data and enable
    typedef struct packed {
        logic [DATA_W-1:0] dout;
        logic oe_n;
    } pin_drive_t;

endpackage

// ===== core/async_fifo_bitbang_port.sv
// Eight-bit parallel port: asynchronous FIFO interface and bit-bang mode.
// Assumes pin inputs already synchronous to core_clk; USB engine is outside.
// Summary of operation
// - FIFO mode moves each byte on read or write strobe falling edge.
// - FIFO mode keeps data bus input, driving only while read strobe low.
// - Data-available flag low whenever a receive byte waits.
// - Flag rises the cycle after read strobe falls; lowers only for next byte.
// - Both flags tristated during reset.
// - Read strobe falling puts current receive byte on data lines.
// - Read strobe rising fetches next receive byte if one exists.
// - Write strobe falling captures data lines into transmit stream.
// - Suspended with wakeup enabled, send-now low pulse requests resume.
// - Powered, send-now low pulse flushes buffered data on next IN.
// - FIFO mode only when configuration memory selects it.
// - Host command enters bit-bang; eight lines become bidirectional bus; code drives all eight throughout (data_oe_n held low).
// - Bit-bang pulses active-low write indication when new data is out.
// - Bit-bang gives sample indication rising edge after sampling lines.
`timescale 1ns/10ps
module async_fifo_bitbang_port
    import pport_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cfg_fifo_mode,
    input wire logic cfg_wakeup_en,
    input wire logic bitbang_cmd,
    input wire logic powered_indication_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_wakeup_n,
    output logic rx_data_available_n,
    output logic rx_flag_oe_n,
    output logic tx_space_available_n,
    output logic tx_flag_oe_n,
    output logic bitbang_write_n,
    output logic bitbang_sample_indication,
    input wire pport_pkg::byte_beat_t usb_rx,
    output logic usb_rx_ready,
    output pport_pkg::byte_beat_t usb_tx,
    input wire logic usb_tx_ready,
    output logic resume_req,
    output logic flush_req
);
    import pport_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    port_mode_t mode_r, mode_nxt;
    rd_state_t rd_r, rd_nxt;
    byte_beat_t rx_hold_r, rx_hold_nxt;
    byte_beat_t tx_r, tx_nxt;
    pin_drive_t pin_r, pin_nxt;
    logic rd_prev_r, rd_prev_nxt;
    logic wr_prev_r, wr_prev_nxt;
    logic sn_prev_r, sn_prev_nxt;
    logic in_reset_r;
    logic bb_wr_r, bb_wr_nxt;
    logic bb_smp_r, bb_smp_nxt;
    logic resume_r, resume_nxt;
    logic flush_r, flush_nxt;
    logic rd_fall, rd_rise, wr_fall, sn_fall;

    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction

    assign rd_fall = fell(rd_prev_r, rd_strobe_n);
    assign rd_rise = fell(rd_strobe_n, rd_prev_r);
    assign wr_fall = fell(wr_prev_r, wr_strobe_n);
    assign sn_fall = fell(sn_prev_r, send_now_wakeup_n);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        rd_nxt = rd_r;
        rx_hold_nxt = rx_hold_r;
        tx_nxt = tx_r;
        pin_nxt = pin_r;
        rd_prev_nxt = rd_strobe_n;
        wr_prev_nxt = wr_strobe_n;
        sn_prev_nxt = send_now_wakeup_n;
        bb_wr_nxt = 1'b1;
        bb_smp_nxt = 1'b0;
        usb_rx_ready = 1'b0;
        if (bitbang_cmd) begin
            mode_nxt = MODE_BITBANG;
        end else if (mode_r == MODE_IDLE && cfg_fifo_mode) begin
            mode_nxt = MODE_FIFO;
        end
        if (usb_tx_ready) begin
            tx_nxt.valid = 1'b0;
        end
        unique case (mode_r)
            MODE_FIFO: begin
                // fetch next byte while strobe high
                usb_rx_ready = ~rx_hold_r.valid & rd_strobe_n & (rd_r != RD_DRIVE);
                if (usb_rx_ready && usb_rx.valid) begin
                    rx_hold_nxt = usb_rx;
                end
                unique case (rd_r)
                    RD_WAIT: begin
                        if (rd_fall && rx_hold_r.valid) begin
                            pin_nxt.dout = rx_hold_r.data;
                            rd_nxt = RD_DRIVE;
                        end
                    end
                    RD_DRIVE: begin
                        // byte consumed once strobe returns high
                        if (rd_rise) begin
                            rx_hold_nxt.valid = 1'b0;
                            rd_nxt = RD_DONE;
                        end
                    end
                    RD_DONE: begin
                        rd_nxt = RD_WAIT;
                    end
                    default: begin
                        rd_nxt = RD_WAIT;
                    end
                endcase
                // drive only while read strobe low
                pin_nxt.oe_n = ~(rd_nxt == RD_DRIVE) | rd_strobe_n;
                if (wr_fall && !tx_nxt.valid) begin
                    tx_nxt = '{valid: 1'b1, data: data_in};
                end
            end
            MODE_BITBANG: begin
                // lines driven from host, sampled back to host
                usb_rx_ready = 1'b1;
                pin_nxt.oe_n = 1'b0;
                if (usb_rx.valid) begin
                    pin_nxt.dout = usb_rx.data;
                    bb_wr_nxt = 1'b0;
                end
                // Skip a cycle after each sample, else a steady drain hides the edges
                if (!tx_nxt.valid && !bb_smp_r) begin
                    tx_nxt = '{valid: 1'b1, data: data_in};
                    bb_smp_nxt = 1'b1;
                end
            end
            default: begin
                pin_nxt.oe_n = 1'b1;
            end
        endcase
    end

    // send-now strobe meaning follows power state
    always_comb begin
        resume_nxt = sn_fall & powered_indication_n & cfg_wakeup_en;
        flush_nxt = sn_fall & ~powered_indication_n;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_IDLE;
            rd_r <= RD_WAIT;
            rx_hold_r <= '0;
            tx_r <= '0;
            pin_r <= '{dout: '0, oe_n: 1'b1};
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
            sn_prev_r <= 1'b1;
            in_reset_r <= RST_FLAG_OE_N;
            bb_wr_r <= 1'b1;
            bb_smp_r <= 1'b0;
            resume_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            rd_r <= rd_nxt;
            rx_hold_r <= rx_hold_nxt;
            tx_r <= tx_nxt;
            pin_r <= pin_nxt;
            rd_prev_r <= rd_prev_nxt;
            wr_prev_r <= wr_prev_nxt;
            sn_prev_r <= sn_prev_nxt;
            in_reset_r <= 1'b0;
            bb_wr_r <= bb_wr_nxt;
            bb_smp_r <= bb_smp_nxt;
            resume_r <= resume_nxt;
            flush_r <= flush_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // flags undriven until first edge after reset
    assign rx_flag_oe_n = in_reset_r;
    assign tx_flag_oe_n = in_reset_r;
    // flag low only with a byte held and read idle
    assign rx_data_available_n = ~(rx_hold_r.valid && rd_r == RD_WAIT && mode_r == MODE_FIFO);
    assign tx_space_available_n = tx_r.valid | (mode_r != MODE_FIFO);
    assign data_out = pin_r.dout;
    assign data_oe_n = pin_r.oe_n;
    assign usb_tx = tx_r;
    assign bitbang_write_n = bb_wr_r;
    assign bitbang_sample_indication = bb_smp_r;
    assign resume_req = resume_r;
    assign flush_req = flush_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence read_low_s;
        $fell(rd_strobe_n) && rx_hold_r.valid && rd_r == RD_WAIT && mode_r == MODE_FIFO;
    endsequence

    bus_drive_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_r == MODE_FIFO && !data_oe_n |-> !rd_strobe_n || $past(!rd_strobe_n))
        else $error("data bus driven with read strobe high");
    read_data_a: assert property (@(posedge core_clk) disable iff (!nrst)
        read_low_s |=> data_out == $past(rx_hold_r.data))
        else $error("read byte not presented");
    flag_rise_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_r == MODE_FIFO && rd_r == RD_DRIVE && $rose(rd_strobe_n) |=> rx_data_available_n)
        else $error("data flag not raised after read");
    flag_avail_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !rx_data_available_n |-> rx_hold_r.valid)
        else $error("data flag low without byte");
    write_capture_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_r == MODE_FIFO && $fell(wr_strobe_n) && !tx_space_available_n
        |=> usb_tx.valid && usb_tx.data == $past(data_in))
        else $error("write byte not captured");
    space_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_r == MODE_FIFO |-> tx_space_available_n == usb_tx.valid)
        else $error("space flag disagrees with fullness");
    resume_req_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(send_now_wakeup_n) && powered_indication_n && cfg_wakeup_en |=> resume_req)
        else $error("resume not requested");
    flush_req_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(send_now_wakeup_n) && !powered_indication_n |=> flush_req && !resume_req)
        else $error("flush not requested");
    bb_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_r == MODE_BITBANG && usb_rx.valid
        |=> !bitbang_write_n && data_out == $past(usb_rx.data))
        else $error("write indication missing");
    bb_sample_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(bitbang_sample_indication) |-> usb_tx.valid && mode_r == MODE_BITBANG)
        else $error("sample indication without sample");

endmodule // async_fifo_bitbang_port

// ===== tb/host_ctl_model.sv
// External controller model for the parallel port.
// Assumes the bench resolves the bus level and feeds it back on bus.
`timescale 1ns/10ps
module host_ctl_model
    import pport_pkg::*;
(
    input wire logic core_clk,
    input wire logic rx_data_available_n,
    input wire logic tx_space_available_n,
    input wire logic [DATA_W-1:0] bus,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic [DATA_W-1:0] drv_data
);
    logic drv_en = 1'b0;
    initial begin
        rd_strobe_n = 1'b1;
        wr_strobe_n = 1'b1;
        drv_data = 8'hA5;
    end
    // Released bus moves every cycle so a stale value never looks valid
    always @(posedge core_clk) begin
        if (!drv_en) begin
            drv_data <= ~drv_data;
        end
    end
    task automatic hold(input logic [DATA_W-1:0] d);
        drv_en = 1'b1;
        drv_data = d;
    endtask
    // Returns just after raising the strobe; caller keeps it high >= 2 cycles
    task automatic rd(output logic [DATA_W-1:0] d);
        for (int i = 0; i < 40 && rx_data_available_n !== 1'b0; i++) @(posedge core_clk) #1;
        rd_strobe_n = 1'b0;
        repeat (4) @(posedge core_clk);
        d = bus;
        #1 rd_strobe_n = 1'b1;
    endtask
    task automatic wr(input logic [DATA_W-1:0] d);
        for (int i = 0; i < 40 && tx_space_available_n !== 1'b0; i++) @(posedge core_clk) #1;
        hold(d);
        wr_strobe_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 wr_strobe_n = 1'b1;
        drv_en = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
endmodule // host_ctl_model

// ===== tb/async_fifo_bitbang_port_test.sv
// Self-checking bench for the parallel port, FIFO and bit-bang modes.
// Assumes host_ctl_model stands in for the external controller.
`timescale 1ns/10ps
module async_fifo_bitbang_port_test;
    import pport_pkg::*;
    logic core_clk = 0, nrst = 0, cfg_fifo_mode = 0, cfg_wakeup_en = 0, bitbang_cmd = 0;
    logic powered_indication_n = 0, send_now_wakeup_n = 1, usb_tx_ready = 0;
    logic [7:0] data_in, data_out, drv_data, d, prev_bus;
    logic data_oe_n, rd_strobe_n, wr_strobe_n, rx_data_available_n, rx_flag_oe_n;
    logic tx_space_available_n, tx_flag_oe_n, bitbang_write_n, bitbang_sample_indication;
    logic usb_rx_ready, resume_req, flush_req;
    byte_beat_t usb_rx = '0, usb_tx;
    int n_errors = 0, compares = 0;
    assign data_in = (data_oe_n === 1'b0) ? data_out : drv_data;
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) prev_bus <= data_in;
    async_fifo_bitbang_port DUT (.core_clk(core_clk), .nrst(nrst), .cfg_fifo_mode(cfg_fifo_mode),
        .cfg_wakeup_en(cfg_wakeup_en), .bitbang_cmd(bitbang_cmd),
        .powered_indication_n(powered_indication_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
        .send_now_wakeup_n(send_now_wakeup_n), .rx_data_available_n(rx_data_available_n),
        .rx_flag_oe_n(rx_flag_oe_n), .tx_space_available_n(tx_space_available_n),
        .tx_flag_oe_n(tx_flag_oe_n), .bitbang_write_n(bitbang_write_n),
        .bitbang_sample_indication(bitbang_sample_indication), .usb_rx(usb_rx),
        .usb_rx_ready(usb_rx_ready), .usb_tx(usb_tx), .usb_tx_ready(usb_tx_ready),
        .resume_req(resume_req), .flush_req(flush_req));
    host_ctl_model ctl (.core_clk(core_clk), .rx_data_available_n(rx_data_available_n),
        .tx_space_available_n(tx_space_available_n), .bus(data_in),
        .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .drv_data(drv_data));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic feed(input logic [7:0] b);
        usb_rx = '{valid: 1'b1, data: b};
        for (int i = 0; i < 40 && usb_rx_ready !== 1'b1; i++) tick();
        tick();
        usb_rx.valid = 1'b0;
    endtask
    task automatic t_reset();
        tick(2);
        chk(rx_flag_oe_n, 8'h01);
        chk(tx_flag_oe_n, 8'h01);
        nrst = 1'b1;
        tick(2);
        chk(rx_flag_oe_n, 8'h00);
        chk(tx_flag_oe_n, 8'h00);
        chk(tx_space_available_n, 8'h01);
        cfg_fifo_mode = 1'b1;
        tick();
    endtask
    task automatic t_read();
        fork
            feed(8'hA5);
            begin
                tick(3);
                chk(rx_data_available_n, 8'h00);
                chk(data_oe_n, 8'h01);
                ctl.rd(d);
            end
        join
        chk(d, 8'hA5);
        fork
            feed(8'h3C);
            tick(1);
        join_any
        chk(rx_data_available_n, 8'h01);
        chk(data_oe_n, 8'h01);
        wait fork;
        chk(rx_data_available_n, 8'h00);
        ctl.rd(d);
        chk(d, 8'h3C);
        tick(3);
    endtask
    task automatic t_write();
        ctl.wr(8'h5A);
        chk({usb_tx.valid, 7'h00}, 8'h80);
        chk(usb_tx.data, 8'h5A);
        chk(tx_space_available_n, 8'h01);
        usb_tx_ready = 1'b1;
        tick();
        usb_tx_ready = 1'b0;
        chk(tx_space_available_n, 8'h00);
        ctl.wr(8'h81);
        chk(usb_tx.data, 8'h81);
        usb_tx_ready = 1'b1;
        tick();
        usb_tx_ready = 1'b0;
    endtask
    task automatic t_send_now();
        int nf, nr;
        for (int k = 0; k < 2; k++) begin
            powered_indication_n = k[0];
            cfg_wakeup_en = k[0];
            nf = 0;
            nr = 0;
            tick(2);
            send_now_wakeup_n = 1'b0;
            for (int i = 0; i < 8; i++) begin
                tick();
                nf += flush_req;
                nr += resume_req;
                if (i == 3) send_now_wakeup_n = 1'b1;
            end
            // flush when powered, resume when suspended
            chk(nf[7:0], k ? 8'h00 : 8'h01);
            chk(nr[7:0], k ? 8'h01 : 8'h00);
        end
        // unused input back at high level
        send_now_wakeup_n = 1'b1;
        powered_indication_n = 1'b0;
    endtask
    task automatic t_bitbang();
        bitbang_cmd = 1'b1;
        usb_rx = '{valid: 1'b1, data: 8'hC3};
        for (int i = 0; i < 20 && bitbang_write_n !== 1'b0; i++) tick();
        usb_rx.valid = 1'b0;
        chk(bitbang_write_n, 8'h00);
        chk(data_out, 8'hC3);
        chk(usb_rx_ready, 8'h01);
        ctl.hold(8'h96);
        usb_tx_ready = 1'b1;
        tick(3);
        for (int i = 0; i < 20 && bitbang_sample_indication !== 1'b1; i++) tick();
        chk(bitbang_sample_indication, 8'h01);
        chk(usb_tx.data, prev_bus);
        tick();
        chk(bitbang_sample_indication, 8'h00);
    endtask
    task automatic test_done();
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        test_done();
    end
    initial begin
        t_reset();
        t_read();
        t_write();
        t_send_now();
        t_bitbang();
        test_done();
    end
endmodule // async_fifo_bitbang_port_test
